//--- rtl/tcc_timer.sv
// tcc_timer.sv: one 16-bit timer channel with clear selection, capture
// edge selection and gated interrupt request, reached over AHB-Lite.
// assumes: single-word transfers, capture inputs synchronous to hclk.
//
// Summary of operation
// [RULE_01] reserved control bits 7:6 and enable bits 7:5 read as one
// [RULE_02] clear field 5:4: none, general 1 event, dedicated 2 match, synchronous
// [RULE_03] synchronous setting clears together with the paired timer's clear
// [RULE_04] general 1 clear uses its match in compare mode, capture otherwise
// [RULE_05] general 2 edge field 3:2: compare, rise, fall, both
// [RULE_06] reset makes general 2 compare; nonzero field makes it capture
// [RULE_07] general 1 edge field 1:0: compare, rise, fall, both
// [RULE_08] reset makes general 1 compare; nonzero field makes it capture
// [RULE_09] interrupt requested when any flag and its enable are both set
// [RULE_10] enable bit 4 gates overflow interrupt, reset zero
// [RULE_11] enable bit 3 gates dedicated 2 match interrupt, reset zero
// [RULE_12] enable bit 2 gates dedicated 1 match interrupt, reset zero
// [RULE_13] enable bit 1 gates general 2 event interrupt, reset zero
// [RULE_14] enable bit 0 gates general 1 event interrupt, reset zero
// [RULE_15] flag clears only by writing zero after reading it as one
// [RULE_16] overflow flag sets when counter wraps from maximum to zero
// [RULE_17] capture copies counter into general register and sets its flag
// [RULE_18] compare mode raises match event when counter equals register
`include "tcc_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module tcc_timer
  import tcc_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // capture inputs and paired timer
  input  wire logic        capture_in1,
  input  wire logic        capture_in2,
  input  wire logic        pair_clear,
  // interrupt request and clear event seen by the paired timer
  output logic             irq,
  output logic             counter_cleared
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [5:0]  ctrl;
  logic [4:0]  irq_en;
  logic [4:0]  flags;
  logic [4:0]  read_seen;
  logic [15:0] count;
  logic [15:0] gen1;
  logic [15:0] gen2;
  logic [15:0] ded1;
  logic [15:0] ded2;
  tcc_phase_t  phase;
  logic        dp_write;
  logic [11:0] dp_addr;

  // ----------------------------------------------------------------
  // capture edges
  // ----------------------------------------------------------------
  tcc_edge_if e1 ();
  tcc_edge_if e2 ();
  assign e1.mode = tcc_edge_t'(ctrl[`TCC_E1_HI:`TCC_E1_LO]); // RULE_07
  assign e2.mode = tcc_edge_t'(ctrl[`TCC_E2_HI:`TCC_E2_LO]); // RULE_05
  assign e1.pin  = capture_in1;
  assign e2.pin  = capture_in2;

  tcc_edge_det u_det1 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .eif     (e1)
  );
  tcc_edge_det u_det2 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .eif     (e2)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // a nonzero edge field turns a general register from compare into capture
  function automatic logic is_capture(input tcc_edge_t mode);
    return mode != TCC_EDGE_NONE;
  endfunction

  // 8-bit registers read back in bits 7:0 with their reserved bits forced high
  function automatic logic [31:0] pad_byte(input logic [7:0] rsvd, input logic [7:0] val);
    return {24'h000000, rsvd | val};
  endfunction

  function automatic logic [31:0] pad_half(input logic [15:0] val);
    return {16'h0000, val};
  endfunction

  // ----------------------------------------------------------------
  // events
  // ----------------------------------------------------------------
  wire       gen1_capture = is_capture(e1.mode);  // RULE_08
  wire       gen2_capture = is_capture(e2.mode);  // RULE_06
  wire       gen1_match   = !gen1_capture && count == gen1; // RULE_18
  wire       gen2_match   = !gen2_capture && count == gen2; // RULE_18
  wire       ded1_match   = (count == ded1);               // RULE_18
  wire       ded2_match   = (count == ded2);               // RULE_18
  wire       gen1_event   = gen1_capture ? e1.hit : gen1_match; // RULE_04
  wire       gen2_event   = gen2_capture ? e2.hit : gen2_match;
  wire       overflow     = (count == `TCC_CNT_MAX);       // RULE_16
  tcc_clr_t  clr_sel;
  assign clr_sel = tcc_clr_t'(ctrl[`TCC_CLR_HI:`TCC_CLR_LO]);

  logic clear_now;
  always_comb begin
    case (clr_sel) // RULE_02
      TCC_CLR_GEN1: clear_now = gen1_event;  // RULE_04
      TCC_CLR_DED2: clear_now = ded2_match;
      TCC_CLR_SYNC: clear_now = pair_clear;  // RULE_03
      default:      clear_now = 1'b0;
    endcase
  end

  wire [4:0] set_ev = {overflow, ded2_match, ded1_match, gen2_event, gen1_event};

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire  take     = hsel & hready & htrans[1];
  wire  do_write = (phase == TCC_PH_DATA) & dp_write;
  wire  wr_ctrl  = do_write & (dp_addr == `TCC_OFS_CTRL);
  wire  wr_irqen = do_write & (dp_addr == `TCC_OFS_IRQEN);
  wire  wr_flags = do_write & (dp_addr == `TCC_OFS_FLAGS);
  wire  wr_count = do_write & (dp_addr == `TCC_OFS_COUNT);
  wire  wr_gen1  = do_write & (dp_addr == `TCC_OFS_GEN1);
  wire  wr_gen2  = do_write & (dp_addr == `TCC_OFS_GEN2);
  wire  wr_ded1  = do_write & (dp_addr == `TCC_OFS_DED1);
  wire  wr_ded2  = do_write & (dp_addr == `TCC_OFS_DED2);
  wire  rd_flags = take & ~hwrite & (haddr == `TCC_OFS_FLAGS);

  logic [31:0] next_rdata;
  always_comb begin
    if (haddr == `TCC_OFS_CTRL) begin
      next_rdata = pad_byte(`TCC_CTRL_RSVD, {2'b00, ctrl});     // RULE_01
    end else if (haddr == `TCC_OFS_IRQEN) begin
      next_rdata = pad_byte(`TCC_IRQEN_RSVD, {3'b000, irq_en}); // RULE_01
    end else if (haddr == `TCC_OFS_FLAGS) begin
      next_rdata = pad_byte(`TCC_FLAGS_RSVD, {3'b000, flags});
    end else if (haddr == `TCC_OFS_COUNT) begin
      next_rdata = pad_half(count);
    end else if (haddr == `TCC_OFS_GEN1) begin
      next_rdata = pad_half(gen1);
    end else if (haddr == `TCC_OFS_GEN2) begin
      next_rdata = pad_half(gen2);
    end else if (haddr == `TCC_OFS_DED1) begin
      next_rdata = pad_half(ded1);
    end else if (haddr == `TCC_OFS_DED2) begin
      next_rdata = pad_half(ded2);
    end else begin
      next_rdata = 32'h00000000;
    end
  end

  // flag clear: a zero written only to bits seen as one; a new event wins
  wire [4:0] clr_mask   = wr_flags ? (read_seen & ~hwdata[4:0]) : 5'h00; // RULE_15
  wire [4:0] next_flags = (flags & ~clr_mask) | set_ev;
  wire [4:0] next_seen  = rd_flags ? flags : (wr_flags ? 5'h00 : read_seen);

  // ----------------------------------------------------------------
  // bus and control registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase     <= TCC_PH_IDLE;
      dp_write  <= 1'b0;
      dp_addr   <= `TCC_OFS_CTRL;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      phase     <= take ? TCC_PH_DATA : TCC_PH_IDLE;
      dp_write  <= take & hwrite;
      dp_addr   <= haddr;
      hrdata    <= (take & ~hwrite) ? next_rdata : 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl   <= 6'h00;   // RULE_06 RULE_08
      irq_en <= 5'h00;   // RULE_10 RULE_11 RULE_12 RULE_13 RULE_14
    end else begin
      if (wr_ctrl) begin
        ctrl <= hwdata[5:0];
      end
      if (wr_irqen) begin
        irq_en <= hwdata[4:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags     <= 5'h00;
      read_seen <= 5'h00;
    end else begin
      flags     <= next_flags;
      read_seen <= next_seen;
    end
  end

  // ----------------------------------------------------------------
  // counter and compare/capture registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count           <= `TCC_CNT_RESET;
      counter_cleared <= 1'b0;
    end else begin
      counter_cleared <= clear_now;
      if (wr_count) begin
        count <= hwdata[15:0];
      end else if (clear_now) begin
        count <= `TCC_CNT_RESET;
      end else begin
        count <= count + 16'h0001;  // RULE_16
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gen1 <= `TCC_CMP_RESET;
      gen2 <= `TCC_CMP_RESET;
      ded1 <= `TCC_CMP_RESET;
      ded2 <= `TCC_CMP_RESET;
    end else begin
      if (gen1_capture && e1.hit) begin
        gen1 <= count;  // RULE_17
      end else if (wr_gen1) begin
        gen1 <= hwdata[15:0];
      end
      if (gen2_capture && e2.hit) begin
        gen2 <= count;  // RULE_17
      end else if (wr_gen2) begin
        gen2 <= hwdata[15:0];
      end
      if (wr_ded1) begin
        ded1 <= hwdata[15:0];
      end
      if (wr_ded2) begin
        ded2 <= hwdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt request
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_flags & irq_en);  // RULE_09
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // every property samples on hclk and is muted while reset is low
  a_irq_gating: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_09
    irq == |($past(next_flags) & $past(irq_en)) || $rose(hresetn))
    else $error("irq does not follow flags and enables");
  a_irq_quiet: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_09
    irq_en == 5'h00 |=> !irq)
    else $error("irq raised with every enable off");
  a_ovf_wrap: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_16
    (count == `TCC_CNT_MAX && !wr_count && !clear_now)
      |=> count == `TCC_CNT_RESET && flags[`TCC_BIT_OVF])
    else $error("wrap did not set overflow flag");
  a_clear_ded2: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_02
    (clr_sel == TCC_CLR_DED2 && ded2_match && !wr_count) |=> count == `TCC_CNT_RESET)
    else $error("dedicated 2 match did not clear counter");
  a_clear_gen1: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_04
    (clr_sel == TCC_CLR_GEN1 && gen1_event && !wr_count) |=> count == `TCC_CNT_RESET)
    else $error("general 1 event did not clear counter");
  a_clear_sync: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_03
    (clr_sel == TCC_CLR_SYNC && pair_clear && !wr_count) |=> count == `TCC_CNT_RESET)
    else $error("paired clear ignored");
  a_clear_none: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_02
    (clr_sel == TCC_CLR_NONE && !wr_count) |=> count == $past(count) + 16'h0001)
    else $error("counter cleared with no source");
  a_clear_pulse: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_02
    clear_now |=> counter_cleared)
    else $error("clear pulse missing");
  a_capture_copy: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_17
    (gen1_capture && e1.hit) |=> gen1 == $past(count) && flags[`TCC_BIT_GEN1])
    else $error("capture did not copy counter");
  a_gen2_copy: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_17
    (gen2_capture && e2.hit) |=> gen2 == $past(count) && flags[`TCC_BIT_GEN2])
    else $error("capture did not copy counter into general 2");
  a_gen1_hold: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_08
    (!gen1_capture && !wr_gen1) |=> gen1 == $past(gen1))
    else $error("compare register 1 changed without a write");
  a_gen2_hold: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_06
    (!gen2_capture && !wr_gen2) |=> gen2 == $past(gen2))
    else $error("compare register 2 changed without a write");
  a_flag_keep: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_15
    (wr_flags && read_seen == 5'h00) |=> (flags & $past(flags)) == $past(flags))
    else $error("flag cleared without prior read");
  a_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_15
    !wr_flags |=> (flags & $past(flags)) == $past(flags))
    else $error("flag cleared without a write");
  a_rsvd_ones: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_01
    (take && !hwrite && haddr == `TCC_OFS_IRQEN) |=> hrdata[7:5] == 3'b111)
    else $error("reserved bits not read as one");
  a_rsvd_ctrl: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_01
    (take && !hwrite && haddr == `TCC_OFS_CTRL) |=> hrdata[7:6] == 2'b11)
    else $error("reserved control bits not read as one");
  a_cmp_match: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_18
    (!gen2_capture && count == gen2) |=> flags[`TCC_BIT_GEN2])
    else $error("compare match missed");
  a_ded1_flag: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_18
    ded1_match |=> flags[`TCC_BIT_DED1])
    else $error("dedicated 1 match missed");
  a_ded2_flag: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_18
    ded2_match |=> flags[`TCC_BIT_DED2])
    else $error("dedicated 2 match missed");
  a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("bus answer not ready and okay");

endmodule // tcc_timer
`default_nettype wire

//--- rtl/tcc_defines.svh
// tcc_defines.svh: register offsets, field positions and reset values
// of the timer clear/capture/interrupt-enable channel.
// assumes: included by its bare name from the rtl sources.
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets on the bus
// ----------------------------------------------------------------
`define TCC_OFS_CTRL     12'h000
`define TCC_OFS_IRQEN    12'h004
`define TCC_OFS_FLAGS    12'h008
`define TCC_OFS_COUNT    12'h00C
`define TCC_OFS_GEN1     12'h010
`define TCC_OFS_GEN2     12'h014
`define TCC_OFS_DED1     12'h018
`define TCC_OFS_DED2     12'h01C

// ----------------------------------------------------------------
// field layouts and reset values
// ----------------------------------------------------------------
`define TCC_CTRL_RSVD    8'hC0
`define TCC_IRQEN_RSVD   8'hE0
`define TCC_FLAGS_RSVD   8'hE0
`define TCC_CLR_HI       5
`define TCC_CLR_LO       4
`define TCC_E2_HI        3
`define TCC_E2_LO        2
`define TCC_E1_HI        1
`define TCC_E1_LO        0
`define TCC_BIT_OVF      4
`define TCC_BIT_DED2     3
`define TCC_BIT_DED1     2
`define TCC_BIT_GEN2     1
`define TCC_BIT_GEN1     0
`define TCC_CNT_MAX      16'hFFFF
`define TCC_CNT_RESET    16'h0000
`define TCC_CMP_RESET    16'hFFFF
`define TCC_FIELD5       5'h1F

`endif

//--- rtl/tcc_pkg.sv
// tcc_pkg.sv: types shared by the timer channel modules.
// assumes: compiled before every other rtl file.
package tcc_pkg;
  typedef enum logic [1:0] {
    TCC_CLR_NONE,
    TCC_CLR_GEN1,
    TCC_CLR_DED2,
    TCC_CLR_SYNC
  } tcc_clr_t;

  typedef enum logic [1:0] {
    TCC_EDGE_NONE,
    TCC_EDGE_RISE,
    TCC_EDGE_FALL,
    TCC_EDGE_BOTH
  } tcc_edge_t;

  typedef enum logic {
    TCC_PH_IDLE,
    TCC_PH_DATA
  } tcc_phase_t;
endpackage

//--- rtl/tcc_edge_if.sv
// tcc_edge_if.sv: capture-edge settings and results between top and detector.
// assumes: one detector per general register.
`timescale 1ns/10ps
`default_nettype none
interface tcc_edge_if;
  import tcc_pkg::*;
  tcc_edge_t mode;
  logic      pin;
  logic      hit;
  modport top (output mode, output pin, input hit);
  modport det (input mode, input pin, output hit);
endinterface
`default_nettype wire

//--- rtl/tcc_edge_det.sv
// tcc_edge_det.sv: qualifying-edge detector for one capture input.
// assumes: pin is synchronous to hclk.
`timescale 1ns/10ps
`default_nettype none
module tcc_edge_det
  import tcc_pkg::*;
(
  // clock and reset
  input  wire logic  hclk,
  input  wire logic  hresetn,
  // settings and result
  tcc_edge_if.det    eif
);
  logic prev;
  wire  rise = eif.pin & ~prev;
  wire  fall = ~eif.pin & prev;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev <= 1'b0;
    end else begin
      prev <= eif.pin;
    end
  end

  always_comb begin
    case (eif.mode)
      TCC_EDGE_RISE: eif.hit = rise;
      TCC_EDGE_FALL: eif.hit = fall;
      TCC_EDGE_BOTH: eif.hit = rise | fall;
      default:       eif.hit = 1'b0;
    endcase
  end
endmodule // tcc_edge_det
`default_nettype wire

//--- verification/tcc_timer_tb.sv
// tcc_timer_tb.sv: self-checking bench for the timer channel over ahb-lite.
// assumes: one slave whose hreadyout is hready, 8-bit registers in bits 7:0,
// counter runs every hclk.
`include "tcc_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module tcc_timer_tb;
  import tcc_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire  logic  hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        capture_in1;
  logic        capture_in2;
  logic        pair_clear;
  logic        irq;
  logic        counter_cleared;
  int          n_fail;
  int          comparisons;
  logic [31:0] d;
  int          n;

  assign hready = hreadyout;

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    capture_in1 = 1'b0;
    capture_in2 = 1'b0;
    pair_clear = 1'b0;
  end
  always #25 hclk = ~hclk;

  tcc_timer i_dut (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .hsel            (hsel),
    .haddr           (haddr),
    .htrans          (htrans),
    .hwrite          (hwrite),
    .hsize           (hsize),
    .hwdata          (hwdata),
    .hready          (hready),
    .hrdata          (hrdata),
    .hreadyout       (hreadyout),
    .hresp           (hresp),
    .capture_in1     (capture_in1),
    .capture_in2     (capture_in2),
    .pair_clear      (pair_clear),
    .irq             (irq),
    .counter_cleared (counter_cleared)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // waits as long as the slave stretches; only the watchdog ends a hang
  task automatic wait_rdy();
    do begin
      @(posedge hclk);
    end while (hready !== 1'b1);
  endtask

  // one single word transfer; read data taken at the edge ending the data phase
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] x;
    xfer(1'b1, a, wd, x);
  endtask

  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] x;
    xfer(1'b0, a, 32'h0, x);
    check(what, x, exp);
    check("hresp okay", {31'h0, hresp}, 32'h0);
  endtask

  // a flag clears only after it has been read as one
  task automatic clr_flags();
    logic [31:0] x;
    xfer(1'b0, `TCC_OFS_FLAGS, 32'h0, x);
    wr(`TCC_OFS_FLAGS, 32'h0);
  endtask

  // counts edges until the clear pulse is sampled, bounded by lim
  task automatic wait_clr(input int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge hclk);
      cnt++;
    end while (counter_cleared !== 1'b1 && cnt < lim);
  endtask

  task automatic results();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    results();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    n_fail = 0;
    comparisons = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk("ctrl reset", `TCC_OFS_CTRL, 32'h000000C0);
    rdchk("irqen reset", `TCC_OFS_IRQEN, 32'h000000E0);
    rdchk("flags reset", `TCC_OFS_FLAGS, 32'h000000E0);
    rdchk("gen1 reset", `TCC_OFS_GEN1, 32'h0000FFFF);
    wr(`TCC_OFS_CTRL, 32'h000000FF);
    rdchk("ctrl all", `TCC_OFS_CTRL, 32'h000000FF);
    wr(`TCC_OFS_CTRL, 32'h00000000);
    rdchk("ctrl rsvd", `TCC_OFS_CTRL, 32'h000000C0);
    wr(`TCC_OFS_IRQEN, 32'h00000000);
    rdchk("irqen rsvd", `TCC_OFS_IRQEN, 32'h000000E0);
    wr(12'h020, 32'h12345678);
    rdchk("unmapped", 12'h020, 32'h00000000);
    // wrap at all-ones also matches the four registers still at all-ones
    wr(`TCC_OFS_COUNT, 32'h0000FFF0);
    repeat (30) @(posedge hclk);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(`TCC_OFS_FLAGS, 32'h00000000);
    rdchk("flags set", `TCC_OFS_FLAGS, 32'h000000FF);
    for (int i = 0; i < 5; i++) begin
      wr(`TCC_OFS_IRQEN, 32'h1 << i);
      repeat (3) @(posedge hclk);
      check("irq gated", {31'h0, irq}, 32'h1);
    end
    wr(`TCC_OFS_FLAGS, 32'h0000001E);
    rdchk("flag gen1 clr", `TCC_OFS_FLAGS, 32'h000000FE);
    // only the general 1 flag is clear now, so its enable alone must stay quiet
    wr(`TCC_OFS_IRQEN, 32'h00000001);
    repeat (3) @(posedge hclk);
    check("irq gen1 off", {31'h0, irq}, 32'h0);
    wr(`TCC_OFS_FLAGS, 32'h00000000);
    rdchk("flags clr", `TCC_OFS_FLAGS, 32'h000000E0);
    repeat (3) @(posedge hclk);
    check("irq low", {31'h0, irq}, 32'h0);
    // dedicated 2 match clears, no clear selected does not
    wr(`TCC_OFS_DED2, 32'h00000100);
    wr(`TCC_OFS_CTRL, 32'h00000020);
    wr(`TCC_OFS_COUNT, 32'h00000000);
    wait_clr(400, n);
    check("ded2 clear", {31'h0, n >= 250 && n <= 265}, 32'h1);
    @(posedge hclk);
    check("clear pulse", {31'h0, counter_cleared}, 32'h0);
    wr(`TCC_OFS_CTRL, 32'h00000000);
    wait_clr(300, n);
    check("no clear", {31'h0, counter_cleared}, 32'h0);
    pair_clear <= 1'b1;
    @(posedge hclk);
    pair_clear <= 1'b0;
    wait_clr(5, n);
    check("pair ignored", {31'h0, counter_cleared}, 32'h0);
    wr(`TCC_OFS_CTRL, 32'h00000030);
    pair_clear <= 1'b1;
    @(posedge hclk);
    pair_clear <= 1'b0;
    wait_clr(5, n);
    check("pair clear", {31'h0, counter_cleared}, 32'h1);
    // general 1 clears by match in compare mode, by capture in capture mode
    wr(`TCC_OFS_GEN1, 32'h00000040);
    wr(`TCC_OFS_CTRL, 32'h00000010);
    wr(`TCC_OFS_COUNT, 32'h00000000);
    wait_clr(200, n);
    check("gen1 match clear", {31'h0, n >= 60 && n <= 72}, 32'h1);
    wr(`TCC_OFS_CTRL, 32'h00000011);
    capture_in1 <= 1'b1;
    wait_clr(5, n);
    check("gen1 capt clear", {31'h0, counter_cleared}, 32'h1);
    capture_in1 <= 1'b0;
    wr(`TCC_OFS_CTRL, 32'h00000000);
    wr(`TCC_OFS_DED1, 32'h0000FFFF);
    wr(`TCC_OFS_DED2, 32'h0000FFFF);
    // every edge setting against a rising and a falling pin
    for (int m = 0; m < 4; m++) begin
      wr(`TCC_OFS_CTRL, (m << 2) | m);
      for (int e = 0; e < 2; e++) begin
        wr(`TCC_OFS_GEN1, 32'h0000AAAA);
        wr(`TCC_OFS_GEN2, 32'h0000AAAA);
        wr(`TCC_OFS_COUNT, 32'h00000000);
        clr_flags();
        // pins move six edges after the counter load, so a capture holds 6
        capture_in1 <= (e == 0);
        capture_in2 <= (e == 0);
        repeat (4) @(posedge hclk);
        rdchk("capt flags", `TCC_OFS_FLAGS, m[e] ? 32'hE3 : 32'hE0);
        xfer(1'b0, `TCC_OFS_GEN1, 32'h0, d);
        check("gen1 capt", d, m[e] ? 32'h00000006 : 32'h0000AAAA);
        xfer(1'b0, `TCC_OFS_GEN2, 32'h0, d);
        check("gen2 capt", d, m[e] ? 32'h00000006 : 32'h0000AAAA);
      end
    end
    // general 1 on rising, general 2 on falling: a swapped field shows here
    wr(`TCC_OFS_CTRL, 32'h00000009);
    clr_flags();
    capture_in1 <= 1'b1;
    capture_in2 <= 1'b1;
    repeat (4) @(posedge hclk);
    rdchk("split edges", `TCC_OFS_FLAGS, 32'h000000E1);
    results();
  end
endmodule // tcc_timer_tb
`default_nettype wire
